//--- logic/sfc_top.sv
// synthesizer frequency control, calibration sequencer and transmit control
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module sfc_top #(
  parameter longint REF_HZ = 26000000
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cmd_sen,
  input  wire logic        cmd_sclk,
  input  wire logic        cmd_sdi,
  input  wire logic        vco_cal_done,
  input  wire logic        lock_raw,
  input  wire logic        tx_data,
  input  wire logic        tx_baud_clk,
  output logic [21:0]      pll_ctrl_word,
  output logic             output_divider_select,
  output logic             vco_cal_run,
  output logic             lock_detector_enable,
  output logic             lock_detect_gated,
  output logic             phase_detector_enable,
  output logic             prescaler_enable,
  output logic             synth_clk_enable,
  output logic             pa_enable,
  output logic             tx_mod_data,
  output logic [7:0]       amp_setting
);
  // ****************************************
  // registers
  // ****************************************
  logic [19:0] slot_reg [4];
  logic [3:0]  tuning_config_reg;
  logic [5:0]  synth_control_reg;
  logic [7:0]  amplitude_setting_a;
  logic [7:0]  amplitude_setting_b;
  logic [7:0]  aw_reg;
  logic [31:0] w_reg;
  logic [3:0]  ws_reg;
  logic        aw_full_reg;
  logic        w_full_reg;
  sfc_pkg::sfc_seq_t seq_reg;
  sfc_pkg::sfc_seq_t seq_next;
  logic [19:0] cal_word_reg;
  logic [11:0] lock_cnt_reg;
  logic        cmd_tx_reg;
  logic        pa_reg;
  logic        pa_off_wait_reg;
  logic [1:0]  cmd_slot_reg;
  logic        sync_reg;
  logic        amp_off_reg;
  logic        manch_reg;
  logic        amp_sel_reg;
  logic        baud_reg;
  logic        data_reg;
  logic [21:0] nfx_reg;
  logic [7:0]  amp_out_reg;
  logic        cmd_valid;
  logic [1:0]  cmd_slot;
  logic        cmd_sync;
  logic        cmd_amp_off;
  logic        cmd_manch;
  logic        cmd_amp_sel;
  logic        pa_start;
  logic        sen_end;
  logic [19:0] rx_ofs [4];

  sfc_cmd_rx u_cmd (
    .core_clk    (core_clk),
    .srst        (srst),
    .cmd_sen     (cmd_sen),
    .cmd_sclk    (cmd_sclk),
    .cmd_sdi     (cmd_sdi),
    .cmd_valid   (cmd_valid),
    .cmd_slot    (cmd_slot),
    .cmd_sync    (cmd_sync),
    .cmd_amp_off (cmd_amp_off),
    .cmd_manch   (cmd_manch),
    .cmd_amp_sel (cmd_amp_sel),
    .pa_start    (pa_start),
    .sen_end     (sen_end)
  );

  // ****************************************
  // bus slave
  // ****************************************
  wire        do_wr   = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire [31:0] wmask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strb
      assign wmask[gi*8 +: 8] = {8{ws_reg[gi]}};
    end
  endgenerate
  wire [31:0] wmerge  = w_reg & wmask;
  wire        wr_hit  = (aw_reg <= sfc_pkg::OFS_AMP_B) & (aw_reg[1:0] == 2'h0);
  wire        rd_hit  = (s_axi_araddr <= sfc_pkg::OFS_AMP_B) & (s_axi_araddr[1:0] == 2'h0);
  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sfc_pkg::RESP_OKAY;
      aw_reg <= 8'h00;
      w_reg  <= 32'h0;
      ws_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_reg <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_reg  <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end else if (do_wr) begin
        w_full_reg <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? sfc_pkg::RESP_OKAY : sfc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) slot_reg[i] <= 20'h0;
      tuning_config_reg   <= 4'h0;
      synth_control_reg   <= 6'h0;
      amplitude_setting_a <= 8'h00;
      amplitude_setting_b <= 8'h00;
    end else if (do_wr) begin
      // narrow fields keep unstrobed bits
      unique case (aw_reg)
        sfc_pkg::OFS_SLOT0:   slot_reg[0] <= (slot_reg[0] & ~wmask[19:0]) | wmerge[19:0];
        sfc_pkg::OFS_SLOT1:   slot_reg[1] <= (slot_reg[1] & ~wmask[19:0]) | wmerge[19:0];
        sfc_pkg::OFS_SLOT2:   slot_reg[2] <= (slot_reg[2] & ~wmask[19:0]) | wmerge[19:0];
        sfc_pkg::OFS_SLOT3:   slot_reg[3] <= (slot_reg[3] & ~wmask[19:0]) | wmerge[19:0];
        sfc_pkg::OFS_TUNING:  tuning_config_reg <=
          (tuning_config_reg & ~wmask[3:0]) | wmerge[3:0];
        sfc_pkg::OFS_CONTROL: synth_control_reg <=
          (synth_control_reg & ~wmask[5:0]) | wmerge[5:0];
        sfc_pkg::OFS_AMP_A:   amplitude_setting_a <=
          (amplitude_setting_a & ~wmask[7:0]) | wmerge[7:0];
        sfc_pkg::OFS_AMP_B:   amplitude_setting_b <=
          (amplitude_setting_b & ~wmask[7:0]) | wmerge[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // frequency word
  // ****************************************
  wire       dbl        = tuning_config_reg[0];
  wire       div_sel    = tuning_config_reg[1];
  wire [1:0] lock_sel   = tuning_config_reg[3:2];
  wire [1:0] device_operating_field   = synth_control_reg[1:0];
  wire       force_en   = synth_control_reg[2];
  wire       force_val  = synth_control_reg[3];
  wire [1:0] mode_slot  = synth_control_reg[5:4];
  wire       rx_mode    = (device_operating_field == sfc_pkg::MODE_RX) & ~cmd_tx_reg;
  // transmit from mode field or command
  wire       tx_mode    = (device_operating_field == sfc_pkg::MODE_TX) | cmd_tx_reg;
  wire       run        = rx_mode | tx_mode;
  // command slot bits pick the word during a command transmit, else the control register slot field
  wire [1:0] act_slot   = cmd_tx_reg ? cmd_slot_reg : mode_slot;

  // offset in steps of the active resolution
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ofs
      // floor keeps the offset just below the nominal
      localparam longint OFS = (sfc_pkg::IF_HZ * sfc_pkg::FRAC_SCALE * (1 + gi / 2))
                               / (REF_HZ * (1 + gi % 2));
      assign rx_ofs[gi] = OFS[19:0];
    end
  endgenerate
  wire [19:0] word_eff  = slot_reg[act_slot] + (rx_mode ? rx_ofs[{div_sel, dbl}] : 20'h0);

  // normal: 2w+1 over sixteen fraction bits
  wire [21:0] nfx_norm  = {sfc_pkg::N_BASE, 16'h0} + {1'b0, word_eff, 1'b1};
  // integer and fraction split at bit 15
  wire [5:0]  dbl_int   = sfc_pkg::N_BASE + {1'b0, word_eff[19:sfc_pkg::INT_LO]};
  wire [21:0] nfx_dbl   = {dbl_int, 16'h0} + {5'h0, word_eff[sfc_pkg::FRAC_HI:0], 2'h2};
  wire [21:0] nfx_sel   = dbl ? nfx_dbl : nfx_norm;
  assign pll_ctrl_word         = nfx_reg;
  assign output_divider_select = div_sel;

  // ****************************************
  // calibration sequencer
  // ****************************************
  // four fixed lock counts
  wire [11:0] lock_tgt  = (lock_sel == 2'h0) ? sfc_pkg::LOCK_CYC0 :
                          (lock_sel == 2'h1) ? sfc_pkg::LOCK_CYC1 :
                          (lock_sel == 2'h2) ? sfc_pkg::LOCK_CYC2 : sfc_pkg::LOCK_CYC3;
  // changed loop word, mode bit included, recalibrates
  wire        recal     = (seq_reg != sfc_pkg::SQ_OFF) & (nfx_sel != nfx_reg);
  wire        cal_busy  = (seq_reg == sfc_pkg::SQ_CAL_START) | (seq_reg == sfc_pkg::SQ_CAL_EN)
                          | (seq_reg == sfc_pkg::SQ_CAL_RUN);
  wire        seq_lock  = cal_busy | (seq_reg == sfc_pkg::SQ_LOCK_WAIT);

  always_comb begin
    seq_next = seq_reg;
    unique case (seq_reg)
      sfc_pkg::SQ_OFF:       if (run) seq_next = sfc_pkg::SQ_CAL_START;
      // one cycle later the loop blocks switch on
      sfc_pkg::SQ_CAL_START: seq_next = sfc_pkg::SQ_CAL_EN;
      sfc_pkg::SQ_CAL_EN:    seq_next = sfc_pkg::SQ_CAL_RUN;
      sfc_pkg::SQ_CAL_RUN:   if (vco_cal_done) seq_next = sfc_pkg::SQ_LOCK_WAIT;
      // ready once lock held for the count
      sfc_pkg::SQ_LOCK_WAIT: if (lock_raw & (lock_cnt_reg >= lock_tgt)) seq_next = sfc_pkg::SQ_READY;
      sfc_pkg::SQ_READY:     ;
    endcase
    if (!run) seq_next = sfc_pkg::SQ_OFF;
    else if (recal) seq_next = sfc_pkg::SQ_CAL_START;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      seq_reg      <= sfc_pkg::SQ_OFF;
      cal_word_reg <= 20'h0;
      lock_cnt_reg <= 12'h0;
      nfx_reg      <= 22'h0;
    end else begin
      seq_reg <= seq_next;
      if (seq_next == sfc_pkg::SQ_CAL_START) begin
        cal_word_reg <= word_eff;
        nfx_reg      <= nfx_sel;
      end
      if (seq_reg != sfc_pkg::SQ_LOCK_WAIT || !lock_raw) lock_cnt_reg <= 12'h0;
      else if (lock_cnt_reg < lock_tgt) lock_cnt_reg <= lock_cnt_reg + 12'h1;
    end
  end

  // detector during sequence, else software force
  assign lock_detector_enable  = seq_lock | (force_en & force_val);
  // lock output held low while calibrating
  assign lock_detect_gated     = lock_raw & lock_detector_enable & ~cal_busy;
  assign vco_cal_run           = cal_busy;
  assign phase_detector_enable = (seq_reg != sfc_pkg::SQ_OFF) & (seq_reg != sfc_pkg::SQ_CAL_START);
  assign prescaler_enable      = phase_detector_enable;
  assign synth_clk_enable      = phase_detector_enable;
  wire   synth_ready_flag      = seq_reg == sfc_pkg::SQ_READY;
  wire   tx_ready_flag         = synth_ready_flag & tx_mode & pa_reg;

  // ****************************************
  // transmit control
  // ****************************************
  wire baud_rise = tx_baud_clk & ~baud_reg;
  wire pa_off    = pa_off_wait_reg & (~sync_reg | baud_rise);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_tx_reg <= 1'b0;
      pa_reg <= 1'b0;
      pa_off_wait_reg <= 1'b0;
      {cmd_slot_reg, sync_reg, amp_off_reg, manch_reg, amp_sel_reg} <= 6'h0;
      baud_reg <= 1'b0;
      data_reg <= 1'b0;
      amp_out_reg <= 8'h00;
    end else begin
      baud_reg <= tx_baud_clk;
      if (cmd_valid) begin
        {cmd_slot_reg, sync_reg, amp_off_reg, manch_reg, amp_sel_reg} <=
          {cmd_slot, cmd_sync, cmd_amp_off, cmd_manch, cmd_amp_sel};
      end
      // amplifier on at the ninth bit edge
      if (pa_start | (synth_ready_flag & (device_operating_field == sfc_pkg::MODE_TX))) pa_reg <= 1'b1;
      else if (pa_off | ~tx_mode) pa_reg <= 1'b0;
      if (pa_start) cmd_tx_reg <= 1'b1;
      else if (pa_off) cmd_tx_reg <= 1'b0;
      // amp-off bit arms turn-off at enable end
      if (sen_end & amp_off_reg & pa_reg) pa_off_wait_reg <= 1'b1;
      else if (pa_off | pa_start) pa_off_wait_reg <= 1'b0;
      // raw, baud aligned, or Manchester coded
      if (manch_reg) begin
        if (baud_rise) data_reg <= tx_data;
      end else if (!sync_reg | baud_rise) begin
        data_reg <= tx_data;
      end
      amp_out_reg <= amp_sel_reg ? amplitude_setting_b : amplitude_setting_a;
    end
  end
  assign pa_enable   = pa_reg;
  assign tx_mod_data = manch_reg ? (data_reg ^ baud_reg) : data_reg;
  assign amp_setting = amp_out_reg;

  // ****************************************
  // read path
  // ****************************************
  wire [31:0] status_word = {25'h0, act_slot, pa_reg, cal_busy, lock_detect_gated,
                             tx_ready_flag, synth_ready_flag};
  wire [31:0] rd_mux =
    (s_axi_araddr == sfc_pkg::OFS_SLOT0)   ? {12'h0, slot_reg[0]} :
    (s_axi_araddr == sfc_pkg::OFS_SLOT1)   ? {12'h0, slot_reg[1]} :
    (s_axi_araddr == sfc_pkg::OFS_SLOT2)   ? {12'h0, slot_reg[2]} :
    (s_axi_araddr == sfc_pkg::OFS_SLOT3)   ? {12'h0, slot_reg[3]} :
    (s_axi_araddr == sfc_pkg::OFS_TUNING)  ? {28'h0, tuning_config_reg} :
    (s_axi_araddr == sfc_pkg::OFS_CONTROL) ? {26'h0, synth_control_reg} :
    (s_axi_araddr == sfc_pkg::OFS_STATUS)  ? status_word :
    (s_axi_araddr == sfc_pkg::OFS_AMP_A)   ? {24'h0, amplitude_setting_a} :
    (s_axi_araddr == sfc_pkg::OFS_AMP_B)   ? {24'h0, amplitude_setting_b} : 32'h0;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= sfc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? sfc_pkg::RESP_OKAY : sfc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  cal_gate_a: assert property (cal_busy |-> !lock_detect_gated)
    else $error("lock output not gated during calibration");
  pfd_delay_a: assert property (seq_reg == sfc_pkg::SQ_CAL_START && run && !recal
    |=> phase_detector_enable && prescaler_enable)
    else $error("loop blocks not enabled one cycle after start");
  start_off_a: assert property (seq_reg == sfc_pkg::SQ_CAL_START |-> !phase_detector_enable)
    else $error("detector enabled too early");
  ready_lock_a: assert property ($rose(synth_ready_flag) |->
    $past(lock_raw) && $past(lock_cnt_reg) >= $past(lock_tgt))
    else $error("ready without lock count");
  recal_clear_a: assert property (recal && run |=> !synth_ready_flag [*2])
    else $error("ready flag survived recalibration");
  det_idle_a: assert property (seq_reg == sfc_pkg::SQ_READY && !force_en
    |-> !lock_detector_enable)
    else $error("detector left on after lock");
  pa_cmd_a: assert property (pa_start |=> pa_enable)
    else $error("amplifier not on after ninth edge");
  dbl_int_a: assert property (dbl && seq_reg == sfc_pkg::SQ_CAL_START |->
    nfx_reg[21:16] == sfc_pkg::N_BASE + {1'b0, cal_word_reg[19:15]})
    else $error("integer part wrong in doubled mode");
  slot_sel_a: assert property (cmd_tx_reg |-> act_slot == cmd_slot_reg)
    else $error("command slot not applied");
  amp_sel_a: assert property (amp_sel_reg |=> amp_setting == $past(amplitude_setting_b))
    else $error("amplitude b not applied");
  cov_ready_c: cover property ($rose(synth_ready_flag));
  cov_tx_c:    cover property ($rose(tx_ready_flag));
  cov_recal_c: cover property (recal && seq_reg == sfc_pkg::SQ_READY);
endmodule

//--- logic/sfc_pkg.sv
// shared constants of the synthesizer control block
package sfc_pkg;
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] OFS_SLOT0     = 8'h00;
  localparam logic [7:0] OFS_SLOT1     = 8'h04;
  localparam logic [7:0] OFS_SLOT2     = 8'h08;
  localparam logic [7:0] OFS_SLOT3     = 8'h0c;
  localparam logic [7:0] OFS_TUNING    = 8'h10;
  localparam logic [7:0] OFS_CONTROL   = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_AMP_A     = 8'h1c;
  localparam logic [7:0] OFS_AMP_B     = 8'h20;
  // ****************************************
  // fields and codes
  // ****************************************
  localparam int         WORD_W        = 20;
  localparam int         FRAC_HI       = 14;
  localparam int         INT_LO        = 15;
  localparam int         NFX_W         = 22;
  localparam logic [5:0] N_BASE        = 6'h20;
  localparam logic [1:0] MODE_RX       = 2'h1;
  localparam logic [1:0] MODE_TX       = 2'h3;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  localparam logic [3:0] CMD_BITS      = 4'h8;
  localparam logic [3:0] CMD_DONE      = 4'h9;
  // ****************************************
  // timing
  // ****************************************
  localparam longint     IF_HZ         = 300000;
  localparam longint     FRAC_SCALE    = 32768;
  localparam logic [11:0] LOCK_CYC0    = 12'h010;
  localparam logic [11:0] LOCK_CYC1    = 12'h040;
  localparam logic [11:0] LOCK_CYC2    = 12'h100;
  localparam logic [11:0] LOCK_CYC3    = 12'h400;
  typedef enum logic [2:0] {SQ_OFF, SQ_CAL_START, SQ_CAL_EN, SQ_CAL_RUN,
                            SQ_LOCK_WAIT, SQ_READY} sfc_seq_t;
endpackage

//--- logic/sfc_cmd_rx.sv
// serial transmit command receiver
`timescale 1ns/1ps
module sfc_cmd_rx (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       cmd_sen,
  input  wire logic       cmd_sclk,
  input  wire logic       cmd_sdi,
  output logic            cmd_valid,
  output logic [1:0]      cmd_slot,
  output logic            cmd_sync,
  output logic            cmd_amp_off,
  output logic            cmd_manch,
  output logic            cmd_amp_sel,
  output logic            pa_start,
  output logic            sen_end
);
  logic       sclk_reg;
  logic       sen_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic       hdr_ok_reg;
  wire        rise     = cmd_sclk & ~sclk_reg;
  wire        fall     = ~cmd_sclk & sclk_reg;
  wire        take     = cmd_sen & rise & (cnt_reg < sfc_pkg::CMD_BITS);
  wire        last_ok  = take & (cnt_reg == sfc_pkg::CMD_BITS - 4'h1)
                         & shift_reg[0] & shift_reg[1];
  // ninth bit active edge is the falling one
  wire        ninth    = cmd_sen & fall & hdr_ok_reg & (cnt_reg == sfc_pkg::CMD_BITS);

  always_ff @(posedge core_clk) begin
    sclk_reg <= cmd_sclk;
    sen_reg  <= cmd_sen;
    if (srst | ~cmd_sen) begin
      cnt_reg    <= 4'h0;
      hdr_ok_reg <= 1'b0;
    end else if (take) begin
      cnt_reg    <= cnt_reg + 4'h1;
      hdr_ok_reg <= last_ok;
    end else if (ninth) begin
      cnt_reg    <= sfc_pkg::CMD_DONE;
    end
    if (take) begin
      shift_reg[cnt_reg[2:0]] <= cmd_sdi;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_valid   <= 1'b0;
      pa_start    <= 1'b0;
      sen_end     <= 1'b0;
      cmd_slot    <= 2'h0;
      cmd_sync    <= 1'b0;
      cmd_amp_off <= 1'b0;
      cmd_manch   <= 1'b0;
      cmd_amp_sel <= 1'b0;
    end else begin
      cmd_valid <= last_ok;
      pa_start  <= ninth;
      sen_end   <= sen_reg & ~cmd_sen;
      // D2..D7 in order, first bit sent first
      if (last_ok) begin
        cmd_slot    <= {shift_reg[2], shift_reg[3]};
        cmd_sync    <= shift_reg[4];
        cmd_amp_off <= shift_reg[5];
        cmd_manch   <= shift_reg[6];
        cmd_amp_sel <= cmd_sdi;
      end
    end
  end
endmodule

//--- sim/sfc_host_model.sv
// host model driving the serial transmit command lines
`timescale 1ns/1ps
module sfc_host_model (
  input  wire logic core_clk,
  output logic      cmd_sen = 1'b0,
  output logic      cmd_sclk = 1'b0,
  output logic      cmd_sdi = 1'b0
);
  // slow serial clock, four core cycles a half period
  localparam int HALF = 4;
  // data set up a half period before each rise
  task automatic send8(input logic [7:0] b);
    @(posedge core_clk);
    cmd_sen <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      cmd_sclk <= 1'b0;
      cmd_sdi <= b[i];
      repeat (HALF) @(posedge core_clk);
      cmd_sclk <= 1'b1;
      repeat (HALF) @(posedge core_clk);
    end
  endtask
  // ninth bit, the falling clock edge
  task automatic ninth();
    @(posedge core_clk);
    cmd_sclk <= 1'b0;
    repeat (HALF) @(posedge core_clk);
  endtask
  // released data line shows no stale value
  task automatic end_frame();
    cmd_sen <= 1'b0;
    cmd_sdi <= ~cmd_sdi;
    repeat (HALF) @(posedge core_clk);
  endtask
endmodule

//--- sim/sfc_top_tb.sv
// self-checking bench for the synthesizer control block
`timescale 1ns/1ps
module sfc_top_tb;
  logic        core_clk = 1'b0, srst = 1'b1, vco_cal_done = 1'b0, lock_raw = 1'b1;
  logic        tx_data = 1'b0, tx_baud_clk = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, amp_setting;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        cmd_sen, cmd_sclk, cmd_sdi, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, output_divider_select, vco_cal_run;
  logic        lock_detector_enable, lock_detect_gated, phase_detector_enable;
  logic        prescaler_enable, synth_clk_enable, pa_enable, tx_mod_data;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [21:0] pll_ctrl_word;
  int          errors, check_count;

  sfc_top u_sfc_top (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_sen, .cmd_sclk, .cmd_sdi,
    .vco_cal_done, .lock_raw, .tx_data, .tx_baud_clk, .pll_ctrl_word, .output_divider_select,
    .vco_cal_run, .lock_detector_enable, .lock_detect_gated, .phase_detector_enable,
    .prescaler_enable, .synth_clk_enable, .pa_enable, .tx_mod_data, .amp_setting);
  sfc_host_model u_sfc_host_model (.core_clk, .cmd_sen, .cmd_sclk, .cmd_sdi);

  always #5 core_clk = ~core_clk;
  // subband search ends one cycle after it starts
  always @(posedge core_clk) vco_cal_done <= vco_cal_run;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge core_clk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge core_clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge core_clk);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge core_clk);
      if (ah) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic cal_walk();
    while (vco_cal_run !== 1'b1) @(negedge core_clk);
    chk(lock_detector_enable, 1'b1);
    chk(lock_detect_gated, 1'b0);
    chk(phase_detector_enable, 1'b0);
    @(negedge core_clk);
    chk({phase_detector_enable, prescaler_enable, synth_clk_enable}, 3'h7);
    while (vco_cal_run === 1'b1) @(negedge core_clk);
  endtask
  // ready must wait out the sixteen-cycle lock count
  task automatic ready_walk();
    repeat (8) @(negedge core_clk);
    axi_rd(sfc_pkg::OFS_STATUS);
    chk(rd[0], 1'b0);
    repeat (24) @(negedge core_clk);
    axi_rd(sfc_pkg::OFS_STATUS);
    chk(rd[0], 1'b1);
  endtask

  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    axi_rd(sfc_pkg::OFS_TUNING);
    chk(rd, 32'h0);
    axi_wr(sfc_pkg::OFS_AMP_A, 32'h5a);
    axi_wr(sfc_pkg::OFS_AMP_B, 32'ha5);
    axi_wr(sfc_pkg::OFS_SLOT0, 32'h12345);
    fork
      axi_wr(sfc_pkg::OFS_CONTROL, 32'h3);
      cal_walk();
    join
    ready_walk();
    chk(pll_ctrl_word, 32'h22468b);
    chk(pa_enable, 1'b1);
    chk(lock_detector_enable, 1'b0);
    axi_wr(sfc_pkg::OFS_CONTROL, 32'hf);
    chk(lock_detector_enable, 1'b1);
    chk(lock_detect_gated, 1'b1);
    fork
      axi_wr(sfc_pkg::OFS_TUNING, 32'h3);
      cal_walk();
    join
    ready_walk();
    chk(pll_ctrl_word, 32'h228d16);
    chk(output_divider_select, 1'b1);
    // receive adds floor(300 kHz / step) = 378 words in this setting
    fork
      axi_wr(sfc_pkg::OFS_CONTROL, 32'h1);
      cal_walk();
    join
    chk(pll_ctrl_word, 32'h2292fe);
    axi_wr(sfc_pkg::OFS_CONTROL, 32'h0);
    u_sfc_host_model.send8(8'h86);
    u_sfc_host_model.ninth();
    u_sfc_host_model.end_frame();
    @(negedge core_clk);
    chk(pa_enable, 1'b0);
    for (int s = 0; s < 4; s++) begin
      u_sfc_host_model.send8({s[0], 3'b010, s[0], s[1], 2'b11});
      @(negedge core_clk);
      chk(pa_enable, 1'b0);
      u_sfc_host_model.ninth();
      @(negedge core_clk);
      chk(pa_enable, 1'b1);
      chk(amp_setting, s[0] ? 32'ha5 : 32'h5a);
      axi_rd(sfc_pkg::OFS_STATUS);
      chk(rd[6:5], s[1:0]);
      u_sfc_host_model.end_frame();
      @(negedge core_clk);
      chk(pa_enable, 1'b0);
    end
    u_sfc_host_model.send8(8'h03);
    u_sfc_host_model.ninth();
    u_sfc_host_model.end_frame();
    repeat (4) @(negedge core_clk);
    chk(pa_enable, 1'b1);
    @(posedge core_clk);
    tx_data <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk(tx_mod_data, 1'b1);
    u_sfc_host_model.send8(8'h43);
    u_sfc_host_model.ninth();
    u_sfc_host_model.end_frame();
    @(posedge core_clk);
    tx_baud_clk <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk(tx_mod_data, 1'b0);
    @(posedge core_clk);
    tx_baud_clk <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk(tx_mod_data, 1'b1);
    axi_rd(8'h24);
    chk(rd, 32'h0);
    chk(rsp, sfc_pkg::RESP_SLVERR);
    axi_wr(8'h24, 32'h1);
    chk(rsp, sfc_pkg::RESP_SLVERR);
    end_of_test();
  end
endmodule
